// >>> common/dac_regs_defines.vh
// Register indexes, field positions, reset values and decode codes for the DAC range block
`ifndef DAC_REGS_DEFINES_VH
`define DAC_REGS_DEFINES_VH

// Register indexes; byte address is four times the index
`define IDX_CHAN_SELECT 4'h3
`define IDX_CHAN_CONFIG 4'h4
`define IDX_OUTPUT_CODE 4'h5
`define IDX_CONV_SELECT 4'h6
`define IDX_CLAMP_CONFIG 4'h7

// Channel select register fields
`define CHAN_PICK_LSB 5
`define CLEAR_PICK_LSB 9

// Channel configuration fields
`define SLEW_LIMIT_BIT 4
`define RANGE_MSB 3
`define RANGE_LSB 0

// Converter clamp configuration fields
`define POLICY_MSB 11
`define POLICY_LSB 10
`define HIGH_CLAMP_MSB 9
`define HIGH_CLAMP_LSB 6
`define LOW_CLAMP_MSB 5
`define LOW_CLAMP_LSB 2

// Clamp policy codes
`define POLICY_TRACK 2'h0
`define POLICY_USER 2'h1
`define POLICY_LEARN 2'h2

// Voltage-mode legal positive clamp codes
`define CLAMP_V_OK0 4'h3
`define CLAMP_V_OK1 4'h8
`define CLAMP_V_OK2 4'h9

// Reset values
`define RST_REG16 16'h0000
`define ZERO_SCALE 16'h0000
`define MID_SCALE 16'h8000

`endif

// >>> hw/code_store.v
// Four-word store of per-channel output codes with masked write and scale loading
`timescale 1ns/100ps
`include "dac_regs_defines.vh"

module code_store (
  input wire clk,
  input wire srst,
  input wire [3:0] we_mask,
  input wire [1:0] byte_en,
  input wire [15:0] wdata,
  input wire [3:0] clr_mask,
  input wire [3:0] clr_mid,
  input wire [1:0] rd_addr,
  output reg [15:0] rdata_r,
  output wire [63:0] words_flat
);
  reg [15:0] mem_r [0:3];
  integer i;

  // Clear has priority; the block never issues both in one cycle anyway
  always @(posedge clk) begin
    for (i = 0; i < 4; i = i + 1) begin
      if (srst) begin
        mem_r[i] <= `ZERO_SCALE;
      end else if (clr_mask[i]) begin
        mem_r[i] <= clr_mid[i] ? `MID_SCALE : `ZERO_SCALE;
      end else if (we_mask[i]) begin
        if (byte_en[1]) begin
          mem_r[i][15:8] <= wdata[15:8];
        end
        if (byte_en[0]) begin
          mem_r[i][7:0] <= wdata[7:0];
        end
      end
    end
  end

  // Registered read port
  always @(posedge clk) begin
    if (srst) begin
      rdata_r <= `ZERO_SCALE;
    end else begin
      rdata_r <= mem_r[rd_addr];
    end
  end

  assign words_flat = {mem_r[3], mem_r[2], mem_r[1], mem_r[0]};
endmodule

// >>> hw/dac_range_regs.v
// Range, output code and converter clamp register bank behind an Avalon-MM slave
`timescale 1ns/100ps
`include "dac_regs_defines.vh"

module dac_range_regs (
  input wire clk,
  input wire srst,
  input wire [5:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output reg waitrequest,
  input wire [15:0] learned_clamp,
  output wire [3:0] slew_limit_on,
  output reg [3:0] range_is_current_r,
  output reg [11:0] range_span_r,
  output wire [63:0] channel_code,
  output wire [3:0] converter_pick,
  output reg [7:0] clamp_policy_r,
  output reg [15:0] high_clamp_level_r,
  output reg [15:0] low_clamp_level_r,
  output reg [3:0] clamp_level_ok_r,
  output reg [3:0] policy_invalid_r
);
  // One-hot access sequence: take, act, answer
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_WORK = 3'b010;
  localparam [2:0] S_DONE = 3'b100;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [15:0] chan_select_r;
  reg [15:0] conv_select_r;
  reg [15:0] cfg_r [0:3];
  reg [15:0] clamp_r [0:3];
  reg [15:0] learn_meta_r;
  reg [15:0] learn_sync_r;
  reg [3:0] clr_mask;
  reg [3:0] code_we;
  reg [15:0] cfg_nxt [0:3];
  reg [15:0] clamp_nxt [0:3];
  reg [31:0] rd_mux;
  reg [15:0] merged;
  reg [3:0] range_dec [0:3];
  // One loop index per process, so no two processes ever write the same variable
  integer cfg_i;
  integer clamp_i;
  integer dec_i;
  integer store_i;
  integer out_i;

  // Register index; the two byte-offset bits are ignored
  wire [3:0] idx = address[5:2];
  wire work = (state_r == S_WORK);
  wire do_wr = work && write;
  wire [3:0] chan_pick = chan_select_r[`CHAN_PICK_LSB+3:`CHAN_PICK_LSB];
  wire [3:0] clear_scale_pick = chan_select_r[`CLEAR_PICK_LSB+3:`CLEAR_PICK_LSB];
  wire [15:0] code_rdata;

  // Byte-lane merge of a 16-bit register with the write data
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] wd;
    input [1:0] be;
    begin
      merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    end
  endfunction

  // Lowest selected unit; reads of a multi-unit register show that one
  // A write may reach several units, but a read can only show one of them
  function [1:0] first_pick;
    input [3:0] sel;
    begin
      if (sel[0]) first_pick = 2'h0;
      else if (sel[1]) first_pick = 2'h1;
      else if (sel[2]) first_pick = 2'h2;
      else first_pick = 2'h3;
    end
  endfunction

  // Range decode: {current, span}
  // All 11xx codes share one current span, so the low two bits do not matter there
  function [3:0] decode_range;
    input [3:0] rng;
    begin
      if (rng[3:2] == 2'h3) begin
        decode_range = 4'hc;
      end else if (rng[3:2] == 2'h1) begin
        decode_range = {2'h2, rng[1:0]};
      end else begin
        decode_range = {1'b0, rng[3], rng[1:0]};
      end
    end
  endfunction

  // High clamp legality for the output mode
  // Current mode accepts every code; only voltage mode narrows the choice
  function clamp_ok;
    input [3:0] code;
    input is_current;
    begin
      clamp_ok = is_current || code == `CLAMP_V_OK0 || code == `CLAMP_V_OK1 ||
        code == `CLAMP_V_OK2;
    end
  endfunction

  // Bus handshake: take at idle, act one edge later, answer for one cycle
  // The done state lets the master drop its request before a new take
  always @* begin
    case (state_r)
      S_IDLE: state_nxt = (read || write) ? S_WORK : S_IDLE;
      S_WORK: state_nxt = S_DONE;
      S_DONE: state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  // Range decode shared by the span outputs and the clamp legality check
  always @* begin
    for (dec_i = 0; dec_i < 4; dec_i = dec_i + 1) begin
      range_dec[dec_i] = decode_range(cfg_r[dec_i][`RANGE_MSB:`RANGE_LSB]);
    end
  end

  // Channel configuration writes and range-change clears
  // Only a real change of range clears; rewriting the same code keeps the output
  always @* begin
    clr_mask = 4'h0;
    for (cfg_i = 0; cfg_i < 4; cfg_i = cfg_i + 1) begin
      cfg_nxt[cfg_i] = cfg_r[cfg_i];
      if (do_wr && idx == `IDX_CHAN_CONFIG && chan_pick[cfg_i]) begin
        cfg_nxt[cfg_i] = merge16(cfg_r[cfg_i], writedata[15:0], byteenable[1:0]);
        if (cfg_nxt[cfg_i][`RANGE_MSB:`RANGE_LSB] != cfg_r[cfg_i][`RANGE_MSB:`RANGE_LSB]) begin
          clr_mask[cfg_i] = 1'b1;
        end
      end
    end
  end

  // Code writes go to every selected channel
  always @* begin
    code_we = (do_wr && idx == `IDX_OUTPUT_CODE) ? chan_pick : 4'h0;
  end

  // Clamp configuration: policy gates which level fields software may set
  // A write that leaves the policy at tracking, learn or invalid sets neither level from the write data
  always @* begin
    merged = 16'h0000;
    for (clamp_i = 0; clamp_i < 4; clamp_i = clamp_i + 1) begin
      clamp_nxt[clamp_i] = clamp_r[clamp_i];
      if (do_wr && idx == `IDX_CLAMP_CONFIG && conv_select_r[clamp_i]) begin
        merged = merge16(clamp_r[clamp_i], writedata[15:0], byteenable[1:0]);
        clamp_nxt[clamp_i][15:12] = merged[15:12];
        clamp_nxt[clamp_i][`POLICY_MSB:`POLICY_LSB] = merged[`POLICY_MSB:`POLICY_LSB];
        clamp_nxt[clamp_i][1:0] = merged[1:0];
        if (merged[`POLICY_MSB:`POLICY_LSB] == `POLICY_USER) begin
          clamp_nxt[clamp_i][`HIGH_CLAMP_MSB:`LOW_CLAMP_LSB] =
            merged[`HIGH_CLAMP_MSB:`LOW_CLAMP_LSB];
        end
      end
      // Learned level overrides any software value in learn policy
      // It is reloaded every cycle, so a level written meanwhile never sticks
      if (clamp_nxt[clamp_i][`POLICY_MSB:`POLICY_LSB] == `POLICY_LEARN) begin
        clamp_nxt[clamp_i][`HIGH_CLAMP_MSB:`HIGH_CLAMP_LSB] =
          learn_sync_r[clamp_i*4 +: 4];
      end
    end
  end

  // Read data mux, valid in the work cycle
  // Reads with no unit picked return zero rather than a stale unit
  always @* begin
    rd_mux = 32'h0000_0000;
    case (idx)
      `IDX_CHAN_SELECT: rd_mux = {16'h0000, chan_select_r};
      `IDX_CHAN_CONFIG: rd_mux = chan_pick == 4'h0 ? 32'h0000_0000 :
        {16'h0000, cfg_r[first_pick(chan_pick)]};
      `IDX_OUTPUT_CODE: rd_mux = chan_pick == 4'h0 ? 32'h0000_0000 :
        {16'h0000, code_rdata};
      `IDX_CONV_SELECT: rd_mux = {16'h0000, conv_select_r};
      `IDX_CLAMP_CONFIG: rd_mux = conv_select_r[3:0] == 4'h0 ? 32'h0000_0000 :
        {16'h0000, clamp_r[first_pick(conv_select_r[3:0])]};
      default: rd_mux = 32'h0000_0000; // Unmapped reads return zero
    endcase
  end

  // Bus state, answer strobe and read data
  // Every register answers on the same edge, so masters see one fixed timing
  always @(posedge clk) begin
    if (srst) begin
      state_r <= S_IDLE;
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      waitrequest <= ~work;
      if (work && read) begin
        readdata <= rd_mux;
      end
    end
  end

  // Learned clamp levels come from the analog side, so synchronise them
  // Each nibble crosses on its own; a level caught while moving settles a cycle later
  always @(posedge clk) begin
    if (srst) begin
      learn_meta_r <= 16'h0000;
      learn_sync_r <= 16'h0000;
    end else begin
      learn_meta_r <= learned_clamp;
      learn_sync_r <= learn_meta_r;
    end
  end

  // Select registers
  // A new pick applies from the next access on, never to the write that sets it
  always @(posedge clk) begin
    if (srst) begin
      chan_select_r <= `RST_REG16;
      conv_select_r <= `RST_REG16;
    end else if (do_wr) begin
      if (idx == `IDX_CHAN_SELECT) begin
        chan_select_r <= merge16(chan_select_r, writedata[15:0], byteenable[1:0]);
      end
      if (idx == `IDX_CONV_SELECT) begin
        conv_select_r <= merge16(conv_select_r, writedata[15:0], byteenable[1:0]);
      end
    end
  end

  // Per-channel configuration and per-converter clamp storage
  // Reset clears every unit, picked or not
  always @(posedge clk) begin
    for (store_i = 0; store_i < 4; store_i = store_i + 1) begin
      if (srst) begin
        cfg_r[store_i] <= `RST_REG16;
        clamp_r[store_i] <= `RST_REG16;
      end else begin
        cfg_r[store_i] <= cfg_nxt[store_i];
        clamp_r[store_i] <= clamp_nxt[store_i];
      end
    end
  end

  // Registered decode of range and clamp state toward the analog side
  always @(posedge clk) begin
    if (srst) begin
      range_is_current_r <= 4'h0;
      range_span_r <= 12'h000;
      clamp_policy_r <= 8'h00;
      high_clamp_level_r <= 16'h0000;
      low_clamp_level_r <= 16'h0000;
      clamp_level_ok_r <= 4'h0;
      policy_invalid_r <= 4'h0;
    end else begin
      for (out_i = 0; out_i < 4; out_i = out_i + 1) begin
        range_is_current_r[out_i] <= range_dec[out_i][3];
        range_span_r[out_i*3 +: 3] <= range_dec[out_i][2:0];
        clamp_policy_r[out_i*2 +: 2] <= clamp_r[out_i][`POLICY_MSB:`POLICY_LSB];
        high_clamp_level_r[out_i*4 +: 4] <= clamp_r[out_i][`HIGH_CLAMP_MSB:`HIGH_CLAMP_LSB];
        low_clamp_level_r[out_i*4 +: 4] <= clamp_r[out_i][`LOW_CLAMP_MSB:`LOW_CLAMP_LSB];
        // Converter i is judged against the mode of channel i, one to one
        clamp_level_ok_r[out_i] <= clamp_ok(clamp_r[out_i][`HIGH_CLAMP_MSB:`HIGH_CLAMP_LSB],
          range_dec[out_i][3]);
        policy_invalid_r[out_i] <= &clamp_r[out_i][`POLICY_MSB:`POLICY_LSB];
      end
    end
  end

  // Slew enable and converter picks are straight register bits
  // Kept as direct bits so a new setting reaches the analog side one edge sooner
  assign slew_limit_on = {cfg_r[3][`SLEW_LIMIT_BIT], cfg_r[2][`SLEW_LIMIT_BIT],
    cfg_r[1][`SLEW_LIMIT_BIT], cfg_r[0][`SLEW_LIMIT_BIT]};
  assign converter_pick = conv_select_r[3:0];

  // Channel codes; range changes load zero or mid scale
  // The store reads through a register; the pick is steady for a whole access
  code_store u_codes (
    .clk(clk),
    .srst(srst),
    .we_mask(code_we),
    .byte_en(byteenable[1:0]),
    .wdata(writedata[15:0]),
    .clr_mask(clr_mask),
    .clr_mid(clear_scale_pick),
    .rd_addr(first_pick(chan_pick)),
    .rdata_r(code_rdata),
    .words_flat(channel_code)
  );
endmodule

// >>> testbench/dac_range_regs_asserts.sv
// Bus timing and register side-effect checks for the range register bank
`timescale 1ns/100ps

module dac_range_regs_chk (
  input wire clk,
  input wire srst,
  input wire [5:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  input wire [31:0] readdata,
  input wire waitrequest,
  input wire [3:0] slew_limit_on,
  input wire [63:0] channel_code,
  input wire [3:0] converter_pick,
  input wire [7:0] clamp_policy_r,
  input wire [3:0] policy_invalid_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Answer lands exactly two edges after a fresh request
  AST_ANSWER_TIME: assert property ($rose(read || write) |-> waitrequest ##1 waitrequest
    ##1 !waitrequest) else $error("answer not on second edge");
  AST_WAIT_ONE: assert property (!waitrequest |-> (read || write) ##1 waitrequest)
    else $error("waitrequest low without request or too long");
  AST_HIGH_ZERO: assert property (read && !waitrequest |-> readdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  AST_UNMAPPED: assert property (read && !waitrequest && (address[5:2] < 4'h3
    || address[5:2] > 4'h7) |-> readdata == 32'h0) else $error("unmapped read not zero");
  AST_CONV_PICK: assert property (write && !waitrequest && address[5:2] == 4'h6
    && byteenable[0] |-> converter_pick == writedata[3:0]) else $error("converter pick wrong");
  AST_CONV_READ: assert property (read && !waitrequest && address[5:2] == 4'h6
    |-> readdata[3:0] == converter_pick) else $error("converter pick readback wrong");
  // Slew enables and codes move only as a result of a write to their own register; codes also move on a config write
  // A reset of a single edge is seen on the edge after it, so a past reset is a cause too
  AST_SLEW_CAUSE: assert property (!$stable(slew_limit_on) |-> $past(srst) ||
    $past(write) && $past(address[5:2]) == 4'h4)
    else $error("slew enable changed without write");
  AST_CODE_CAUSE: assert property (!$stable(channel_code) |-> $past(srst) ||
    $past(write) && $past(address[5:2]) inside {4'h4, 4'h5})
    else $error("code changed without write");
  AST_POLICY_BAD: assert property (policy_invalid_r[0] == (clamp_policy_r[1:0] == 2'h3))
    else $error("invalid policy flag wrong");
  COV_CLAMP_WR: cover property (write && !waitrequest && address[5:2] == 4'h7);
  COV_CFG_RD: cover property (read && !waitrequest && address[5:2] == 4'h4);
  COV_LEARN: cover property (clamp_policy_r[1:0] == 2'h2);
endmodule

bind dac_range_regs dac_range_regs_chk u_chk (.clk(clk), .srst(srst), .address(address),
  .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest), .slew_limit_on(slew_limit_on),
  .channel_code(channel_code), .converter_pick(converter_pick),
  .clamp_policy_r(clamp_policy_r), .policy_invalid_r(policy_invalid_r));

// >>> testbench/tb_top.sv
// Self-checking bench for the range, output code and converter clamp registers
`timescale 1ns/100ps

module tb_top;
  logic clk, srst, read, write;
  logic [5:0] address;
  logic [31:0] writedata, q;
  logic [3:0] byteenable;
  logic [15:0] learned_clamp;
  wire [31:0] readdata;
  wire waitrequest;
  wire [3:0] slew_limit_on, range_is_current_r, converter_pick, clamp_level_ok_r, policy_invalid_r;
  wire [11:0] range_span_r;
  wire [63:0] channel_code;
  wire [7:0] clamp_policy_r;
  wire [15:0] high_clamp_level_r, low_clamp_level_r;
  int errors = 0, num_checks = 0, cyc = 0, i;
  typedef struct packed {logic [3:0] idx; logic [15:0] wd; logic [15:0] rd;} row_t;
  // Register, value written, value read back; config goes before code since a range move clears it
  row_t rows [6] = '{'{4'h3, 16'h0020, 16'h0020}, '{4'h6, 16'hfff5, 16'hfff5},
    '{4'h4, 16'h0013, 16'h0013}, '{4'h5, 16'h1234, 16'h1234},
    '{4'h7, 16'ha4c8, 16'ha4c8}, '{4'h0, 16'h5555, 16'h0000}};

  dac_range_regs u_dac_range_regs (.clk(clk), .srst(srst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .learned_clamp(learned_clamp), .slew_limit_on(slew_limit_on),
    .range_is_current_r(range_is_current_r), .range_span_r(range_span_r),
    .channel_code(channel_code), .converter_pick(converter_pick),
    .clamp_policy_r(clamp_policy_r), .high_clamp_level_r(high_clamp_level_r),
    .low_clamp_level_r(low_clamp_level_r), .clamp_level_ok_r(clamp_level_ok_r),
    .policy_invalid_r(policy_invalid_r));

  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Hang guard; the whole run needs well under two thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One Avalon access; request held until waitrequest is sampled low, then a idle edge
  task automatic bus(input logic we, input logic [3:0] idx, input logic [15:0] d,
    output logic [31:0] rd);
    int n;
    n = 0;
    address <= {idx, 2'b00};
    writedata <= {16'h0000, d};
    byteenable <= 4'hf;
    read <= !we;
    write <= we;
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) errors++;
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask

  // Expected current flag and span index for a range code
  function automatic logic [3:0] dec(input logic [3:0] r);
    return {r[2], (r[3] & r[2]) ? 3'h4 : {r[3], r[1:0]}};
  endfunction

  initial begin
    srst = 1;
    read = 0;
    write = 0;
    address = 0;
    writedata = 0;
    byteenable = 0;
    learned_clamp = 16'h0909;
    repeat (20) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    chk("waitrequest", waitrequest, 1);
    for (i = 3; i < 8; i++) begin
      bus(0, i, 0, q);
      chk("reset value", q, 0);
    end
    foreach (rows[i]) begin
      bus(1, rows[i].idx, rows[i].wd, q);
      bus(0, rows[i].idx, 0, q);
      chk("readback", q, rows[i].rd);
    end
    chk("slew on", slew_limit_on, 4'h1);
    chk("high clamp", high_clamp_level_r, 16'h0303);
    chk("clamp ok volt", clamp_level_ok_r[0], 1);
    chk("converter pick", converter_pick, 4'h5);
    chk("clamp policy", clamp_policy_r, 8'h11);
    chk("low clamp", low_clamp_level_r, 16'h0202);
    // Every range code differs from the last; rewriting the same code must not clear
    for (i = 0; i < 16; i++) begin
      bus(1, 5, 16'h1234, q);
      bus(1, 4, i, q);
      chk("range decode", {range_is_current_r[0], range_span_r[2:0]}, dec(i));
      chk("range clear", channel_code[15:0], 16'h0000);
      bus(1, 5, 16'h1234, q);
      bus(1, 4, i, q);
      chk("range rewrite", channel_code[15:0], 16'h1234);
    end
    chk("slew off", slew_limit_on, 4'h0);
    bus(1, 3, 16'h0220, q);
    bus(1, 5, 16'h1234, q);
    bus(1, 4, 16'h0001, q);
    chk("mid scale", channel_code[15:0], 16'h8000);
    bus(1, 7, 16'h0400, q);
    chk("clamp bad volt", clamp_level_ok_r[0], 0);
    bus(1, 4, 16'h0004, q);
    chk("clamp ok cur", clamp_level_ok_r[0], 1);
    bus(1, 7, 16'h0cc0, q);
    chk("policy invalid", policy_invalid_r[0], 1);
    chk("clamp kept", high_clamp_level_r, 16'h0000);
    bus(1, 7, 16'h0800, q);
    bus(1, 7, 16'h08c0, q);
    repeat (6) @(posedge clk);
    chk("learned clamp", high_clamp_level_r, 16'h0909);
    // Mid-run reset of one edge, then the bus must answer as after power-up
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk("reset codes", channel_code[31:0] | channel_code[63:32], 0);
    chk("reset pick", converter_pick, 0);
    chk("reset clamp", {clamp_policy_r, high_clamp_level_r}, 0);
    chk("reset range", {range_is_current_r, range_span_r}, 0);
    bus(0, 6, 0, q);
    chk("reset readback", q, 0);
    print_verdict();
  end
endmodule
